/* File: core/fosr_pkg.sv */
// package: offsets, field layouts, codes and reset values of the status bank
package fosr_pkg;

   // bus geometry
   localparam int FOSR_ADDR_W = 13;  // byte address, covers index 0x75e * 4
   localparam int FOSR_DATA_W = 32;  // apb data width

   // register indices; the byte address is four times the index
   localparam logic [10:0] FOSR_IDX_TORQUE = 11'h608;
   localparam logic [10:0] FOSR_IDX_SD_ST  = 11'h682;
   localparam logic [10:0] FOSR_IDX_SD_SPD = 11'h68c;
   localparam logic [10:0] FOSR_IDX_PD_ST  = 11'h6c0;
   localparam logic [10:0] FOSR_IDX_PD_ANG = 11'h704;
   localparam logic [10:0] FOSR_IDX_BEMF_D = 11'h74a;
   localparam logic [10:0] FOSR_IDX_BEMF_Q = 11'h74c;
   localparam logic [10:0] FOSR_IDX_SPD    = 11'h75a;
   localparam logic [10:0] FOSR_IDX_ANG    = 11'h75e;

   // reset values
   localparam logic [31:0] FOSR_RST_W32 = 32'h0000_0000;
   localparam logic [15:0] FOSR_RST_W16 = 16'h0000;

   // initial-speed-detection sequence codes
   typedef enum logic [15:0] {
      SD_INIT      = 16'h0000,
      SD_STOP_CHK  = 16'h0001,
      SD_EST_INIT  = 16'h0002,
      SD_RUN_CHK   = 16'h0003,
      SD_DIR_CHK   = 16'h0004,
      SD_COMPLETE  = 16'h0005,
      SD_FAULT     = 16'h0006
   } fosr_sd_state_e;

   // initial-position-detection sequence codes
   typedef enum logic [15:0] {
      PD_INIT      = 16'h0000,
      PD_VEC_CFG   = 16'h0001,
      PD_RUN       = 16'h0002,
      PD_RISE_CLK  = 16'h0003,
      PD_FALL_CLK  = 16'h0004,
      PD_DECAY     = 16'h0005,
      PD_TIMES     = 16'h0006,
      PD_NEXT_VEC  = 16'h0007,
      PD_SECTOR    = 16'h0008,
      PD_POSITION  = 16'h0009,
      PD_ANGLE     = 16'h000a,
      PD_COMPLETE  = 16'h000b,
      PD_FAULT     = 16'h000c
   } fosr_pd_state_e;

   // values published by the control algorithm
   typedef struct packed {
      logic [31:0] torque_current_reference;
      logic [15:0] speed_detect_state;
      logic [31:0] speed_detect_speed;
      logic [15:0] position_detect_state;
      logic [31:0] position_detect_angle;
      logic [31:0] d_axis_bemf_estimate;
      logic [31:0] q_axis_bemf_estimate;
      logic [31:0] rotor_speed_estimate;
      logic [31:0] rotor_angle_estimate;
   } fosr_val_s;

   // one update strobe per value
   typedef struct packed {
      logic torque_current_reference;
      logic speed_detect_state;
      logic speed_detect_speed;
      logic position_detect_state;
      logic position_detect_angle;
      logic d_axis_bemf_estimate;
      logic q_axis_bemf_estimate;
      logic rotor_speed_estimate;
      logic rotor_angle_estimate;
   } fosr_vld_s;

   // whole bank at reset
   localparam fosr_val_s FOSR_RST_VAL = '{
      FOSR_RST_W32, FOSR_RST_W16, FOSR_RST_W32, FOSR_RST_W16, FOSR_RST_W32,
      FOSR_RST_W32, FOSR_RST_W32, FOSR_RST_W32, FOSR_RST_W32};

endpackage : fosr_pkg

/* File: core/fosr_status_regs.sv */
// apb read-only status bank of the sensorless motor observer
// Function
// - torque current reference, signed 32-bit word
// - torque reference at 0x608, resets zero
// - speed-detect state, 16 bits at 0x682
// - speed-detect codes 0 to 6
// - speed-detect speed word at 0x68c
// - position-detect state at 0x6c0, codes 0-c
// - position-detect angle word at 0x704
// - d-axis back-emf estimate at 0x74a
// - q-axis back-emf estimate at 0x74c
// - signed rotor speed estimate at 0x75a
// - rotor angle estimate at 0x75e
`timescale 1ns/1ns
`default_nettype none

module fosr_status_regs (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [fosr_pkg::FOSR_ADDR_W-1:0] paddr,
   input  wire logic [fosr_pkg::FOSR_DATA_W-1:0] pwdata,
   output var  logic [fosr_pkg::FOSR_DATA_W-1:0] prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   input  wire fosr_pkg::fosr_vld_s           upd_vld,
   input  wire fosr_pkg::fosr_val_s           upd_val,
   output var  logic                          speed_detect_done,
   output var  logic                          speed_detect_fault,
   output var  logic                          position_detect_done,
   output var  logic                          position_detect_fault
);
   import fosr_pkg::*;

   // byte addresses built from the printed indices
   localparam logic [12:0] ADR_TORQUE = {FOSR_IDX_TORQUE, 2'b00};
   localparam logic [12:0] ADR_SD_ST  = {FOSR_IDX_SD_ST, 2'b00};
   localparam logic [12:0] ADR_SD_SPD = {FOSR_IDX_SD_SPD, 2'b00};
   localparam logic [12:0] ADR_PD_ST  = {FOSR_IDX_PD_ST, 2'b00};
   localparam logic [12:0] ADR_PD_ANG = {FOSR_IDX_PD_ANG, 2'b00};
   localparam logic [12:0] ADR_BEMF_D = {FOSR_IDX_BEMF_D, 2'b00};
   localparam logic [12:0] ADR_BEMF_Q = {FOSR_IDX_BEMF_Q, 2'b00};
   localparam logic [12:0] ADR_SPD    = {FOSR_IDX_SPD, 2'b00};
   localparam logic [12:0] ADR_ANG    = {FOSR_IDX_ANG, 2'b00};

   fosr_val_s   val_q;        // status bank contents
   logic [31:0] rd_data_d;    // read word for the addressed register
   logic        rd_err_d;     // address hits no register
   logic [31:0] prdata_q;     // registered read data
   logic        pready_q;     // registered ready
   logic        pslverr_q;    // registered error
   logic        setup;        // apb setup cycle seen
   logic        sd_done_q;    // speed detection finished
   logic        sd_fault_q;   // speed detection failed
   logic        pd_done_q;    // position detection finished
   logic        pd_fault_q;   // position detection failed

   // pwdata has nothing to land in; the bank is read-only
   assign setup = psel && !penable;

   // values follow the algorithm strobes only; the bus has no write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         val_q <= FOSR_RST_VAL;
      end else begin
         // each field loads on its own strobe and holds otherwise
         if (upd_vld.torque_current_reference) begin
            val_q.torque_current_reference <=
               upd_val.torque_current_reference;
         end
         if (upd_vld.speed_detect_state) begin
            val_q.speed_detect_state <= upd_val.speed_detect_state;
         end
         if (upd_vld.speed_detect_speed) begin
            val_q.speed_detect_speed <= upd_val.speed_detect_speed;
         end
         if (upd_vld.position_detect_state) begin
            val_q.position_detect_state <=
               upd_val.position_detect_state;
         end
         if (upd_vld.position_detect_angle) begin
            val_q.position_detect_angle <=
               upd_val.position_detect_angle;
         end
         if (upd_vld.d_axis_bemf_estimate) begin
            val_q.d_axis_bemf_estimate <=
               upd_val.d_axis_bemf_estimate;
         end
         if (upd_vld.q_axis_bemf_estimate) begin
            val_q.q_axis_bemf_estimate <=
               upd_val.q_axis_bemf_estimate;
         end
         if (upd_vld.rotor_speed_estimate) begin
            val_q.rotor_speed_estimate <=
               upd_val.rotor_speed_estimate;
         end
         if (upd_vld.rotor_angle_estimate) begin
            val_q.rotor_angle_estimate <=
               upd_val.rotor_angle_estimate;
         end
      end
   end

   // address decode; 16-bit fields sit low, upper half reads zero
   always_comb begin
      rd_data_d = FOSR_RST_W32;
      rd_err_d  = 1'b0;
      // full address compare, so an unaligned lane never aliases a word
      case (paddr)
         ADR_TORQUE: begin
            rd_data_d = val_q.torque_current_reference;
         end
         ADR_SD_ST: begin
            rd_data_d = {FOSR_RST_W16, val_q.speed_detect_state};
         end
         ADR_SD_SPD: begin
            rd_data_d = val_q.speed_detect_speed;
         end
         ADR_PD_ST: begin
            rd_data_d = {FOSR_RST_W16, val_q.position_detect_state};
         end
         ADR_PD_ANG: begin
            rd_data_d = val_q.position_detect_angle;
         end
         ADR_BEMF_D: begin
            rd_data_d = val_q.d_axis_bemf_estimate;
         end
         ADR_BEMF_Q: begin
            rd_data_d = val_q.q_axis_bemf_estimate;
         end
         ADR_SPD: begin
            rd_data_d = val_q.rotor_speed_estimate;
         end
         ADR_ANG: begin
            rd_data_d = val_q.rotor_angle_estimate;
         end
         default: begin
            // unmapped or unaligned: error, data zero
            rd_err_d = 1'b1;
         end
      endcase
   end

   // answer prepared at setup, so the access phase never waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= FOSR_RST_W32;
      end else begin
         pready_q  <= setup;
         // mapped writes complete cleanly but are dropped
         pslverr_q <= setup && rd_err_d;
         // writes return zero data; only reads carry a value
         prdata_q  <= (setup && !pwrite) ? rd_data_d : FOSR_RST_W32;
      end
   end

   // sequence end flags decoded from the stored state codes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_done_q  <= 1'b0;
         sd_fault_q <= 1'b0;
         pd_done_q  <= 1'b0;
         pd_fault_q <= 1'b0;
      end else begin
         sd_done_q  <= val_q.speed_detect_state == SD_COMPLETE;
         sd_fault_q <= val_q.speed_detect_state == SD_FAULT;
         pd_done_q  <= val_q.position_detect_state == PD_COMPLETE;
         pd_fault_q <= val_q.position_detect_state == PD_FAULT;
      end
   end

   // outputs straight from flip-flops
   assign prdata                = prdata_q;
   assign pready                = pready_q;
   assign pslverr               = pslverr_q;
   assign speed_detect_done     = sd_done_q;
   assign speed_detect_fault    = sd_fault_q;
   assign position_detect_done  = pd_done_q;
   assign position_detect_fault = pd_fault_q;

   // checks on the bank; all in the pclk domain
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a read set up at address a returns v one edge later
   property p_read(logic [12:0] a, logic [31:0] v);
      setup && !pwrite && paddr == a
         |=> pready && !pslverr && prdata == $past(v);
   endproperty

   a_torque_read: assert property (
      p_read(ADR_TORQUE, val_q.torque_current_reference))
      else $error("torque reference read mismatch");

   // during reset the bank is all zero; reset disable overridden; looked
   // at from the second reset edge, the first may still see power-up state
   a_reset_zero: assert property (
      disable iff (1'b0) !presetn ##1 !presetn
         |-> val_q == FOSR_RST_VAL && !pready && !pslverr)
      else $error("bank not zero during reset");

   a_sd_state_read: assert property (
      setup && !pwrite && paddr == ADR_SD_ST
         |=> prdata[31:16] == FOSR_RST_W16
          && prdata[15:0] == $past(val_q.speed_detect_state))
      else $error("speed-detect state read mismatch");

   a_sd_done_flag: assert property (
      upd_vld.speed_detect_state && upd_val.speed_detect_state == SD_COMPLETE
         |=> ##1 speed_detect_done && !speed_detect_fault)
      else $error("speed-detect complete flag not raised");

   a_sd_speed_read: assert property (
      p_read(ADR_SD_SPD, val_q.speed_detect_speed))
      else $error("speed-detect speed read mismatch");

   a_pd_fault_flag: assert property (
      upd_vld.position_detect_state
         && upd_val.position_detect_state == PD_FAULT
         |=> ##1 position_detect_fault && !position_detect_done)
      else $error("position-detect fault flag not raised");

   a_pd_angle_read: assert property (
      p_read(ADR_PD_ANG, val_q.position_detect_angle))
      else $error("position angle read mismatch");

   a_bemf_d_read: assert property (
      p_read(ADR_BEMF_D, val_q.d_axis_bemf_estimate))
      else $error("d-axis estimate read mismatch");

   a_bemf_q_read: assert property (
      p_read(ADR_BEMF_Q, val_q.q_axis_bemf_estimate))
      else $error("q-axis estimate read mismatch");

   // a fresh value is visible to a read set up on the next edge
   a_speed_update: assert property (
      upd_vld.rotor_speed_estimate ##1 setup && !pwrite && paddr == ADR_SPD
         |=> prdata == $past(upd_val.rotor_speed_estimate, 2))
      else $error("rotor speed update not readable");

   a_angle_read: assert property (
      p_read(ADR_ANG, val_q.rotor_angle_estimate))
      else $error("rotor angle read mismatch");

   a_write_ignored: assert property (
      setup && pwrite && upd_vld == '0 |=> $stable(val_q))
      else $error("bus write altered the status bank");

   a_ready_one_cycle: assert property (
      setup |=> pready ##1 !pready)
      else $error("access phase not exactly one cycle");

   a_unmapped_err: assert property (
      setup && rd_err_d |=> pready && pslverr && prdata == FOSR_RST_W32)
      else $error("unmapped access not flagged");

   // a mapped address must never raise an error
   a_mapped_no_err: assert property (
      setup && !rd_err_d |=> pready && !pslverr)
      else $error("mapped access flagged as error");

   // writes answer with zero data so no stale word leaks out
   a_write_zero_data: assert property (
      setup && pwrite |=> pready && prdata == FOSR_RST_W32)
      else $error("write returned non-zero data");

   a_rotor_speed_read: assert property (
      p_read(ADR_SPD, val_q.rotor_speed_estimate))
      else $error("rotor speed read mismatch");

   a_pd_state_read: assert property (
      setup && !pwrite && paddr == ADR_PD_ST
         |=> prdata[31:16] == FOSR_RST_W16
          && prdata[15:0] == $past(val_q.position_detect_state))
      else $error("position-detect state read mismatch");

   a_sd_fault_flag: assert property (
      upd_vld.speed_detect_state && upd_val.speed_detect_state == SD_FAULT
         |=> ##1 speed_detect_fault && !speed_detect_done)
      else $error("speed-detect fault flag not raised");

   a_pd_done_flag: assert property (
      upd_vld.position_detect_state
         && upd_val.position_detect_state == PD_COMPLETE
         |=> ##1 position_detect_done && !position_detect_fault)
      else $error("position-detect complete flag not raised");

   // flags track the stored code one edge late, whatever the code
   a_sd_flags_track: assert property (
      speed_detect_done
         == ($past(val_q.speed_detect_state) == SD_COMPLETE)
      && speed_detect_fault
         == ($past(val_q.speed_detect_state) == SD_FAULT))
      else $error("speed-detect flags do not follow the state");

   a_pd_flags_track: assert property (
      position_detect_done
         == ($past(val_q.position_detect_state) == PD_COMPLETE)
      && position_detect_fault
         == ($past(val_q.position_detect_state) == PD_FAULT))
      else $error("position-detect flags do not follow the state");

   // main scenarios
   c_read_speed: cover property (
      setup && !pwrite && paddr == ADR_SPD ##1 pready);
   c_write_dropped: cover property (
      setup && pwrite && paddr == ADR_TORQUE ##1 pready && !pslverr);
   c_unmapped: cover property (setup && rd_err_d ##1 pslverr);
   c_pd_complete: cover property (position_detect_done);
   c_sd_fault: cover property (speed_detect_fault);

endmodule : fosr_status_regs

`default_nettype wire

/* File: tb/fosr_status_regs_tb_top.sv */
// testbench: apb reads, updates, codes and ignored writes of the status bank
`timescale 1ns/1ns
`default_nettype none

module fosr_status_regs_tb_top;
   import fosr_pkg::*;

   logic                   pclk;      // 100 mhz bus clock
   logic                   presetn;   // async reset, active low
   logic                   psel;      // apb select
   logic                   penable;   // apb access phase
   logic                   pwrite;    // apb direction
   logic [FOSR_ADDR_W-1:0] paddr;     // byte address
   logic [FOSR_DATA_W-1:0] pwdata;    // write data, always ignored
   logic [FOSR_DATA_W-1:0] prdata;    // read data
   logic                   pready;    // transfer complete
   logic                   pslverr;   // transfer error
   fosr_vld_s              upd_vld;   // algorithm load strobes
   fosr_val_s              upd_val;   // algorithm values
   logic                   sd_done;   // speed detect complete flag
   logic                   sd_fault;  // speed detect fault flag
   logic                   pd_done;   // position detect complete flag
   logic                   pd_fault;  // position detect fault flag
   int                     fails;     // mismatch count
   int                     checked;   // comparison count
   logic [10:0]            idx_tbl [9]; // indices in struct field order
   logic [31:0]            exp_tbl [9]; // expected words, same order
   logic [31:0]            rd;        // last read data
   logic                   err;       // last error response

   fosr_status_regs u_fosr_status_regs (
      .pclk                  (pclk),
      .presetn               (presetn),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .upd_vld               (upd_vld),
      .upd_val               (upd_val),
      .speed_detect_done     (sd_done),
      .speed_detect_fault    (sd_fault),
      .position_detect_done  (pd_done),
      .position_detect_fault (pd_fault)
   );

   // free running clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready seen at an edge
   task automatic apb(input logic wr, input logic [10:0] idx,
                      input logic [1:0] lo, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, lo};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd  = prdata;
      err = pslverr;
      // a missing answer counts as a mismatch
      if (n >= 16) chk({31'h0, pready}, 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one-cycle load strobe from the algorithm side
   task automatic upd(input fosr_vld_s m, input fosr_val_s v);
      @(posedge pclk);
      upd_vld <= m;
      upd_val <= v;
      @(posedge pclk);
      upd_vld <= '0;
   endtask : upd

   // read the whole bank against the expected table
   task automatic rd_all();
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, idx_tbl[i], 2'b00, 32'h0);
         chk(rd, exp_tbl[i]);
         chk({31'h0, err}, 32'h0);
      end
   endtask : rd_all

   // every word reads zero after reset
   task automatic test_reset();
      foreach (exp_tbl[i]) exp_tbl[i] = 32'h0;
      rd_all();
      chk({28'h0, sd_done, sd_fault, pd_done, pd_fault}, 32'h0);
      $display("test reset done");
   endtask : test_reset

   // signed and unsigned words loaded together, read back at each offset
   task automatic test_values();
      fosr_val_s v;
      fosr_vld_s m;
      v = '{32'h8000_0001, 16'h0003, 32'h0800_0000, 16'h000a,
            32'hf000_0000, 32'h1234_5678, 32'hedcb_a988,
            32'hff00_0000, 32'h7fff_ffff};
      upd('1, v);
      exp_tbl = '{32'h8000_0001, 32'h3, 32'h0800_0000, 32'ha,
                  32'hf000_0000, 32'h1234_5678, 32'hedcb_a988,
                  32'hff00_0000, 32'h7fff_ffff};
      rd_all();
      // strobe then read on the very next edge: the new word must show
      m = '0;
      m.rotor_speed_estimate = 1'b1;
      v.rotor_speed_estimate = 32'h8765_4321;
      fork
         upd(m, v);
         begin
            @(posedge pclk);
            apb(1'b0, FOSR_IDX_SPD, 2'b00, 32'h0);
         end
      join
      chk(rd, 32'h8765_4321);
      exp_tbl[7] = 32'h8765_4321;
      $display("test values done");
   endtask : test_values

   // walk every sequence code, only the two state words strobed
   task automatic test_codes();
      fosr_vld_s m;
      fosr_val_s v;
      m = '0;
      m.speed_detect_state    = 1'b1;
      m.position_detect_state = 1'b1;
      v = '0;
      for (int c = 0; c <= 12; c++) begin
         v.speed_detect_state    = 16'(c);
         v.position_detect_state = 16'(c);
         upd(m, v);
         apb(1'b0, FOSR_IDX_SD_ST, 2'b00, 32'h0);
         chk(rd, 32'(c));
         apb(1'b0, FOSR_IDX_PD_ST, 2'b00, 32'h0);
         chk(rd, 32'(c));
         chk({30'h0, sd_done, sd_fault}, {30'h0, c == 5, c == 6});
         chk({30'h0, pd_done, pd_fault}, {30'h0, c == 11, c == 12});
      end
      exp_tbl[1] = 32'hc;
      exp_tbl[3] = 32'hc;
      rd_all();
      $display("test codes done");
   endtask : test_codes

   // writes complete but change nothing; stray addresses are refused
   task automatic test_writes();
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, idx_tbl[i], 2'b00, 32'hffff_ffff);
         chk({31'h0, err}, 32'h0);
         chk(rd, 32'h0);
      end
      rd_all();
      apb(1'b0, 11'h609, 2'b00, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, FOSR_IDX_SPD, 2'b10, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 11'h000, 2'b00, 32'h5a5a_5a5a);
      chk({31'h0, err}, 32'h1);
      $display("test writes done");
   endtask : test_writes

   // verdict, the only place the run ends
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   // main sequence
   initial begin
      fails   = 0;
      checked = 0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      upd_vld = '0;
      upd_val = '0;
      idx_tbl = '{FOSR_IDX_TORQUE, FOSR_IDX_SD_ST, FOSR_IDX_SD_SPD,
                  FOSR_IDX_PD_ST, FOSR_IDX_PD_ANG, FOSR_IDX_BEMF_D,
                  FOSR_IDX_BEMF_Q, FOSR_IDX_SPD, FOSR_IDX_ANG};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_values();
      test_codes();
      test_writes();
      test_done();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      test_done();
   end

endmodule : fosr_status_regs_tb_top

`default_nettype wire
